//--- common/ircg_pkg.sv
// constants and types for the infrared carrier generator
// Summary of operation
// RULE1: one 9-bit counter, separate high/low period registers
// RULE2: low-period bit nine always reads zero
// RULE3: counter advances at twice oscillator rate
// RULE4: half-period programmable 250 ns to 64 us
// RULE5: half-period lasts modulo value plus one counts
// RULE6: software loads only 001h to 1ffh
// RULE7: carrier only when carrier_disable bit is zero
// RULE8: program periods before starting the timer
// RULE9: carrier starts with low phase on timer start
// RULE10: down counter zero halts carrier, output low
// RULE11: zero during high phase finishes high first
// RULE12: output low, carrier, or steady high by table
// RULE13: write periods only while remote_output is low
// RULE14: periods accessed by nibble or whole 10-bit word; nibbles here cover bits 3:0 and 9:8 only
// RULE15: software-driven pulses honour minimum widths
// RULE16: fewer carrier cycles possible in high-speed mode
// RULE17: down counter decrements every 64 oscillator periods
// RULE18: reload counter from phase value, toggle at terminal
`default_nettype none
package ircg_pkg;
  localparam int unsigned CNT_W = 9;
  localparam int unsigned MOD_W = 10;
  localparam int unsigned DISABLE_BIT = 9;
  // oscillator periods per down-counter step
  localparam int unsigned OSC_PER_TICK = 64;
  // counter ticks per oscillator period
  localparam int unsigned TICKS_PER_OSC = 2;
  localparam logic [MOD_W-1:0] LOW_RESET = 10'h001;
  localparam logic [MOD_W-1:0] HIGH_RESET = 10'h201;
  // period access selectors
  localparam logic [1:0] SEL_LOW_NIB_LO = 2'h0;
  localparam logic [1:0] SEL_LOW_NIB_HI = 2'h1;
  localparam logic [1:0] SEL_HIGH_NIB_LO = 2'h2;
  localparam logic [1:0] SEL_HIGH_NIB_HI = 2'h3;
  typedef enum logic [1:0] {IRCG_IDLE, IRCG_LOW, IRCG_HIGH} ircg_phase_e;
endpackage
`default_nettype wire

//--- hdl/ircg_half_counter.sv
// reloadable 9-bit half-period counter with terminal flag
`default_nettype none
module ircg_half_counter #(
  parameter int unsigned WIDTH = ircg_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  input wire logic run_i,
  output logic terminal_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } ircg_cnt_s;
  ircg_cnt_s st;
  ircg_cnt_s next_st;

  if (WIDTH < 2) begin : g_width_chk
    $error("ircg_half_counter: WIDTH too small");
  end

  // terminal after value+1 counts; not gated by load so no loop through the caller
  assign terminal_o = run_i && (st.cnt == '0); // RULE5

  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.cnt = value_i; // RULE18
    end else if (run_i && st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

//--- hdl/ircg_carrier.sv
// carrier generator with period registers and remote output
`default_nettype none
module ircg_carrier #(
  parameter int unsigned CNT_W = ircg_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // full 10-bit load: sel_high_i picks high-period register
  input wire logic word_we_i,
  input wire logic sel_high_i,
  input wire logic [ircg_pkg::MOD_W-1:0] word_i,
  // nibble access
  input wire logic nib_we_i,
  input wire logic [1:0] nib_sel_i,
  input wire logic [3:0] nib_i,
  output logic [3:0] nib_o,
  output logic [ircg_pkg::MOD_W-1:0] carrier_low_period_o,
  output logic [ircg_pkg::MOD_W-1:0] carrier_high_period_o,
  // timer side
  input wire logic timer_start_i,
  input wire logic timer_output_enable_i,
  input wire logic timer_nonzero_i,
  output logic remote_output_o
);
  typedef struct packed {
    logic [ircg_pkg::MOD_W-1:0] low_period;
    logic [ircg_pkg::MOD_W-1:0] high_period;
    ircg_pkg::ircg_phase_e phase;
    logic remote_output;
  } ircg_state_s;
  ircg_state_s st;
  ircg_state_s next_st;

  logic load;
  logic [CNT_W-1:0] load_val;
  logic terminal;
  logic carrier_disable;
  logic run;

  // 9 count bits span 250 ns to 64 us per half at the doubled clock
  if (CNT_W != ircg_pkg::CNT_W) begin : g_cnt_w_chk // RULE4
    $error("ircg_carrier: counter must be 9 bits");
  end
  if (ircg_pkg::MOD_W != CNT_W + 1) begin : g_mod_w_chk
    $error("ircg_carrier: period registers need one flag bit above the count");
  end
  if (ircg_pkg::DISABLE_BIT != CNT_W) begin : g_flag_pos_chk
    $error("ircg_carrier: disable flag must sit just above the count");
  end
  if (ircg_pkg::LOW_RESET[ircg_pkg::MOD_W-1] != 1'b0) begin : g_low_rst_chk
    $error("ircg_carrier: low period reset value must keep bit nine clear");
  end
  if (ircg_pkg::LOW_RESET[CNT_W-1:0] == '0) begin : g_low_zero_chk
    $error("ircg_carrier: low period reset value must be a legal nonzero period");
  end

  // selector decode shared by nibble write and nibble read
  function automatic logic sel_targets_high(input logic [1:0] sel);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      ircg_pkg::SEL_LOW_NIB_LO: hit = 1'b0;
      ircg_pkg::SEL_LOW_NIB_HI: hit = 1'b0;
      ircg_pkg::SEL_HIGH_NIB_LO: hit = 1'b1;
      ircg_pkg::SEL_HIGH_NIB_HI: hit = 1'b1;
    endcase
    sel_targets_high = hit;
  endfunction

  function automatic logic sel_is_top(input logic [1:0] sel);
    logic top;
    top = 1'b0;
    unique case (sel)
      ircg_pkg::SEL_LOW_NIB_LO: top = 1'b0;
      ircg_pkg::SEL_LOW_NIB_HI: top = 1'b1;
      ircg_pkg::SEL_HIGH_NIB_LO: top = 1'b0;
      ircg_pkg::SEL_HIGH_NIB_HI: top = 1'b1;
    endcase
    sel_is_top = top;
  endfunction

  // low period keeps bit nine at zero whatever is written
  function automatic logic [ircg_pkg::MOD_W-1:0] clamp_low(input logic [ircg_pkg::MOD_W-1:0] v);
    clamp_low = {1'b0, v[ircg_pkg::MOD_W-2:0]};
  endfunction

  function automatic logic [3:0] pick_nib(input logic [ircg_pkg::MOD_W-1:0] r, input logic hi);
    if (hi) begin
      pick_nib = {2'h0, r[9:8]};
    end else begin
      pick_nib = r[3:0];
    end
  endfunction

  function automatic logic [ircg_pkg::MOD_W-1:0] put_nib(input logic [ircg_pkg::MOD_W-1:0] r,
      input logic hi, input logic [3:0] n);
    logic [ircg_pkg::MOD_W-1:0] v;
    v = r;
    if (hi) begin
      v[9:8] = n[1:0];
    end else begin
      v[3:0] = n;
    end
    put_nib = v;
  endfunction

  // remote output level from enable, disable bit, timer state and phase
  function automatic logic out_level(input logic enable, input logic carrier_off, input logic nonzero,
      input ircg_pkg::ircg_phase_e phase);
    logic level;
    level = 1'b0;
    if (!enable) begin
      level = 1'b0; // RULE12 RULE15
    end else if (carrier_off) begin
      level = nonzero; // RULE12
    end else begin
      level = (phase == ircg_pkg::IRCG_HIGH); // RULE12 RULE10
    end
    out_level = level;
  endfunction

  // next half of the carrier; a start always opens with the low half
  function automatic ircg_pkg::ircg_phase_e phase_after(input ircg_pkg::ircg_phase_e phase, input logic start,
      input logic nonzero, input logic term);
    ircg_pkg::ircg_phase_e nxt;
    nxt = phase;
    if (start) begin
      nxt = ircg_pkg::IRCG_LOW; // RULE9
    end else begin
      unique case (phase)
        ircg_pkg::IRCG_IDLE: begin
          nxt = ircg_pkg::IRCG_IDLE;
        end
        ircg_pkg::IRCG_LOW: begin
          if (!nonzero) begin
            nxt = ircg_pkg::IRCG_IDLE; // RULE10 RULE16 RULE17
          end else if (term) begin
            nxt = ircg_pkg::IRCG_HIGH; // RULE18
          end
        end
        ircg_pkg::IRCG_HIGH: begin
          if (term) begin
            // the high half runs to its end even after the timer ran out
            nxt = nonzero ? ircg_pkg::IRCG_LOW : ircg_pkg::IRCG_IDLE; // RULE11
          end
        end
        default: begin
          nxt = ircg_pkg::IRCG_IDLE;
        end
      endcase
    end
    phase_after = nxt;
  endfunction

  function automatic logic [CNT_W-1:0] reload_value(input ircg_pkg::ircg_phase_e phase,
      input logic [ircg_pkg::MOD_W-1:0] low, input logic [ircg_pkg::MOD_W-1:0] high);
    if (phase == ircg_pkg::IRCG_HIGH) begin
      reload_value = high[CNT_W-1:0];
    end else begin
      reload_value = low[CNT_W-1:0];
    end
  endfunction

  assign carrier_disable = st.high_period[ircg_pkg::DISABLE_BIT]; // RULE7
  // every clock edge is one count of the doubled oscillator
  assign run = st.phase != ircg_pkg::IRCG_IDLE; // RULE3

  ircg_half_counter #(.WIDTH(CNT_W)) u_cnt ( // RULE1
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(load),
    .value_i(load_val),
    .run_i(run),
    .terminal_o(terminal)
  );

  always_comb begin
    next_st = st;
    // a whole-word write wins over a nibble write in the same cycle
    if (word_we_i) begin // RULE14
      if (sel_high_i) begin
        next_st.high_period = word_i;
      end else begin
        next_st.low_period = clamp_low(word_i); // RULE2
      end
    end else if (nib_we_i) begin // RULE14
      if (sel_targets_high(nib_sel_i)) begin
        next_st.high_period = put_nib(st.high_period, sel_is_top(nib_sel_i), nib_i);
      end else begin
        next_st.low_period = clamp_low(put_nib(st.low_period, sel_is_top(nib_sel_i), nib_i)); // RULE2
      end
    end
    next_st.phase = phase_after(st.phase, timer_start_i, timer_nonzero_i, terminal);
    // reload on start and on every change of half, never on the way to idle
    load = timer_start_i || (terminal && (next_st.phase != ircg_pkg::IRCG_IDLE)); // RULE18
    load_val = reload_value(next_st.phase, st.low_period, st.high_period); // RULE18
    // output registered from the phase it will be in
    next_st.remote_output = out_level(timer_output_enable_i, carrier_disable, timer_nonzero_i, next_st.phase);
  end

  // clocked copy of the whole state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st.low_period <= ircg_pkg::LOW_RESET;
      st.high_period <= ircg_pkg::HIGH_RESET;
      st.phase <= ircg_pkg::IRCG_IDLE;
      st.remote_output <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // nibble read is combinational; bits 7:4 have no nibble of their own
  assign nib_o = pick_nib(sel_targets_high(nib_sel_i) ? st.high_period : st.low_period,
      sel_is_top(nib_sel_i));
  assign carrier_low_period_o = st.low_period;
  assign carrier_high_period_o = st.high_period;
  assign remote_output_o = st.remote_output;
endmodule
`default_nettype wire

//--- test/ircg_led_model.sv
// infrared led load: measures run lengths of the remote output
`default_nettype none
module ircg_led_model (
  input wire logic clk_i,
  input wire logic led_i,
  output logic [15:0] hi_len_o,
  output logic [15:0] lo_len_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 1'b0;
  logic [15:0] run = 16'h0001;
  always @(posedge clk_i) begin
    prev <= led_i;
    run <= (led_i != prev) ? 16'h0001 : run + 16'h0001;
    if (led_i != prev && prev) hi_len_o <= run;
    if (led_i != prev && !prev) lo_len_o <= run;
  end
endmodule
`default_nettype wire

//--- test/ircg_carrier_asserts.sv
// concurrent checks on the carrier generator ports
`default_nettype none
module ircg_carrier_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic word_we_i,
  input wire logic sel_high_i,
  input wire logic [9:0] word_i,
  input wire logic [1:0] nib_sel_i,
  input wire logic [3:0] nib_o,
  input wire logic [9:0] carrier_low_period_o,
  input wire logic [9:0] carrier_high_period_o,
  input wire logic timer_start_i,
  input wire logic timer_output_enable_i,
  input wire logic timer_nonzero_i,
  input wire logic remote_output_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  low_bit_zero_a: assert property (!carrier_low_period_o[9]) else $error("low period bit nine set");
  low_write_a: assert property (word_we_i && !sel_high_i |=> carrier_low_period_o == ($past(word_i) & 10'h1ff))
    else $error("low period write lost");
  high_write_a: assert property (word_we_i && sel_high_i |=> carrier_high_period_o == $past(word_i))
    else $error("high period write lost");
  nib_read_a: assert property (nib_sel_i == ircg_pkg::SEL_LOW_NIB_HI |-> nib_o == {2'h0, carrier_low_period_o[9:8]})
    else $error("nibble read wrong");
  start_low_a: assert property (timer_start_i && !carrier_high_period_o[9] |=> !remote_output_o)
    else $error("carrier did not start low");
  enable_off_a: assert property (!timer_output_enable_i |=> !remote_output_o) else $error("output high while disabled");
  zero_stays_a: assert property (!timer_nonzero_i && !remote_output_o |=> !remote_output_o)
    else $error("output rose with counter zero");
  steady_high_a: assert property ((timer_output_enable_i && timer_nonzero_i && carrier_high_period_o[9]) [*2]
    |=> remote_output_o) else $error("steady level missing");
  min_high_a: assert property ($rose(remote_output_o) && !carrier_high_period_o[9] ##1 timer_output_enable_i
    |-> remote_output_o) else $error("high phase too short");
endmodule
bind ircg_carrier ircg_carrier_chk u_chk (.*);
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the carrier generator
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, nrst_i = 1'b0, word_we_i = 1'b0, sel_high_i = 1'b0, nib_we_i = 1'b0;
  logic timer_start_i = 1'b0, timer_output_enable_i = 1'b0, timer_nonzero_i = 1'b0, remote_output_o;
  logic [9:0] word_i = 10'h000, lo_q, hi_q;
  logic [1:0] nib_sel_i = 2'h0;
  logic [3:0] nib_i = 4'h0, nib_o;
  logic [15:0] hi_len, lo_len;
  int fail_count = 0, checks_done = 0;
  ircg_carrier u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .word_we_i(word_we_i), .sel_high_i(sel_high_i),
    .word_i(word_i), .nib_we_i(nib_we_i), .nib_sel_i(nib_sel_i), .nib_i(nib_i), .nib_o(nib_o),
    .carrier_low_period_o(lo_q), .carrier_high_period_o(hi_q), .timer_start_i(timer_start_i),
    .timer_output_enable_i(timer_output_enable_i), .timer_nonzero_i(timer_nonzero_i),
    .remote_output_o(remote_output_o));
  ircg_led_model u_led (.clk_i(clk_i), .led_i(remote_output_o), .hi_len_o(hi_len), .lo_len_o(lo_len));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic hi, logic [9:0] v);
    @(posedge clk_i);
    word_we_i <= 1'b1;
    sel_high_i <= hi;
    word_i <= v;
    @(posedge clk_i);
    word_we_i <= 1'b0;
  endtask
  task automatic nib(logic [1:0] s, logic [3:0] v);
    @(posedge clk_i);
    nib_we_i <= 1'b1;
    nib_sel_i <= s;
    nib_i <= v;
    @(posedge clk_i);
    nib_we_i <= 1'b0;
  endtask
  task automatic start();
    @(posedge clk_i);
    timer_start_i <= 1'b1;
    @(posedge clk_i);
    timer_start_i <= 1'b0;
  endtask
  task automatic t_regs();
    chk("low reset", lo_q, 10'h001);
    chk("high reset", hi_q, 10'h201);
    wr(1'b0, 10'h3ff);
    wr(1'b1, 10'h155);
    nib(ircg_pkg::SEL_LOW_NIB_LO, 4'h6);
    nib(ircg_pkg::SEL_LOW_NIB_HI, 4'h2);
    nib(ircg_pkg::SEL_HIGH_NIB_HI, 4'h2);
    @(negedge clk_i);
    chk("low word", lo_q, 10'h0f6);
    chk("high word", hi_q, 10'h255);
    chk("nibble read", nib_o, 4'h2);
  endtask
  task automatic t_carrier();
    wr(1'b0, 10'h002);
    wr(1'b1, 10'h004);
    timer_output_enable_i <= 1'b1;
    timer_nonzero_i <= 1'b1;
    start();
    repeat (30) @(negedge clk_i);
    chk("low run", lo_len, 16'h0003);
    chk("high run", hi_len, 16'h0005);
    for (int i = 0; i < 20 && !remote_output_o; i++) @(negedge clk_i);
    @(posedge clk_i);
    timer_nonzero_i <= 1'b0;
    repeat (12) @(negedge clk_i);
    chk("last high run", hi_len, 16'h0005);
    chk("stopped output", remote_output_o, 1'b0);
    timer_nonzero_i <= 1'b1;
    start();
    timer_nonzero_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk("cut in low", remote_output_o, 1'b0);
  endtask
  task automatic t_steady();
    wr(1'b1, 10'h204);
    timer_nonzero_i <= 1'b1;
    start();
    repeat (3) @(negedge clk_i);
    chk("steady high", remote_output_o, 1'b1);
    @(posedge clk_i);
    timer_output_enable_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("disabled low", remote_output_o, 1'b0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    t_regs();
    t_carrier();
    t_steady();
    test_done();
  end
endmodule
`default_nettype wire
